// [include/synth_pkg.sv]
// constants and decode helpers for the synthesiser control block
package synth_pkg;
	localparam int WORD_W = 20;
	localparam int DIV_W = 14;
	localparam int DIV_LSB = 0;
	localparam int SEL_LO_BIT = 14;
	localparam int SEL_HI_BIT = 15;
	localparam int PORT_LSB = 16;
	localparam int PORT_W = 4;
	localparam logic [13:0] PRESCALE = 14'h0010;
	localparam logic [19:0] WORD_RST = 20'h00000;
	localparam logic [1:0] CUR_50 = 2'h0;
	localparam logic [1:0] CUR_150 = 2'h1;
	localparam logic [1:0] CUR_170 = 2'h2;
	localparam logic [2:0] TC_DN170 = 3'h0;
	localparam logic [2:0] TC_UP170 = 3'h1;
	localparam logic [2:0] TC_DN50 = 3'h4;
	localparam logic [2:0] TC_UP50 = 3'h5;
	localparam logic [1:0] TC_ROUTE = 2'h2;
	localparam logic [1:0] TC_FORCE = 2'h3;
	localparam int PIN_EN = 0;
	localparam int PIN_RF = 1;
	localparam int PIN_TST = 2;
	localparam int PIN_CPD = 3;
	localparam int PIN_DRV = 4;
	localparam int PIN_SKP = 5;
	localparam int PIN_N = 6;
	localparam logic [7:0] OFF_WORD = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_LOCK = 8'h08;
	localparam logic [7:0] LOCK_THR_RST = 8'h08;
	localparam logic [7:0] LOCK_WIN = 8'h04;

	// reference divide ratio from halving skip and {low, high} select
	function automatic logic [8:0] ref_ratio(input logic skip,
		input logic [1:0] code);
		logic [8:0] r;
		case ({skip, code})
			3'h0: r = 9'h118;
			3'h1: r = 9'h032;
			3'h2: r = 9'h1F4;
			3'h3: r = 9'h064;
			3'h4: r = 9'h08C;
			3'h5: r = 9'h019;
			3'h6: r = 9'h0FA;
			default: r = 9'h032;
		endcase
		return r;
	endfunction : ref_ratio
endpackage : synth_pkg

// [include/pump_if.sv]
// detector outputs shared between detector and top
interface pump_if;
	logic up;
	logic dn;
	logic locked;
	modport det (output up, output dn, output locked);
	modport sink (input up, input dn, input locked);
endinterface : pump_if

// [rtl/div_pulse.sv]
// pulse divider: one output pulse per ratio input pulses
module div_pulse
	import synth_pkg::*;
#(
	parameter int W = 14
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_pulse,
	input wire logic [W-1:0] ratio,
	output logic out_pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic out;
	} div_t;
	div_t q;
	div_t d;
	logic wrap;

	assign wrap = ({1'b0, q.cnt} + {{W{1'b0}}, 1'b1}) >= {1'b0, ratio};

	always_comb begin
		d = q;
		d.out = 1'b0;
		if (in_pulse) begin
			if (wrap) begin
				d.cnt = '0;
				d.out = 1'b1;
			end else begin
				d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_pulse = q.out;

	a_div_count: assert property (@(posedge clk) disable iff (!rst_n)
		in_pulse && wrap |=> out_pulse && q.cnt == '0)
		else $error("divider missed its terminal count");
endmodule : div_pulse

// [rtl/pfd_lock.sv]
// phase frequency detector with lock qualification
module pfd_lock
	import synth_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_p,
	input wire logic div_p,
	input wire logic [7:0] thr,
	pump_if.det pif
);
	typedef struct packed {
		logic up;
		logic dn;
		logic [7:0] err;
		logic [7:0] good;
		logic locked;
	} pfd_t;
	pfd_t q;
	pfd_t d;

	always_comb begin
		d = q;
		if (ref_p) begin
			d.up = 1'b1;
		end
		if (div_p) begin
			d.dn = 1'b1;
		end
		if ((q.up | ref_p) && (q.dn | div_p)) begin
			d.up = 1'b0;
			d.dn = 1'b0;
		end
		if ((q.up ^ q.dn) && q.err != 8'hFF) begin
			d.err = q.err + 8'h01;
		end
		if (ref_p) begin
			d.err = 8'h00;
			if (q.err > LOCK_WIN) begin
				d.good = 8'h00;
			end else if (q.good != 8'hFF) begin
				d.good = q.good + 8'h01;
			end
		end
		d.locked = d.good >= thr;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pif.up = q.up;
	assign pif.dn = q.dn;
	assign pif.locked = q.locked;

	a_pfd_clear: assert property (@(posedge clk) disable iff (!rst_n)
		ref_p && div_p && !q.up && !q.dn |=> !q.up && !q.dn)
		else $error("detector did not cancel coincident edges");
endmodule : pfd_lock

// [rtl/synth_ctrl.sv]
// top of the three-wire bus synthesiser control block
// Overview of operation
// - shift data only while enable high
// - clock edges ignored while enable low
// - word latched on enable falling edge
// - one 20-bit word through one port
// - main divider uses 14-bit divisor
// - divide-by-16 prescaler before main divider
// - reference ratio from skip and selects
// - detector compares phase and frequency
// - lock flag driven, else high impedance
// - pump 150 uA, 50 uA once locked
// - port sinks when its bit is one
// - test mode picks function from port bits
// - test codes force pump direction, current
// - x10 routes signals, x11 forces lock
// - data-line condition disables pump output
// - enable-line condition disables varactor drive
//
// Decided for this implementation: the APB slave port and the placing of the registers.
module synth_ctrl
	import synth_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic LINK_CLK,
	input wire logic LINK_DATA,
	input wire logic LINK_EN,
	input wire logic RF_IN,
	input wire logic REF_HALVING_SKIP,
	input wire logic TEST_REQ,
	input wire logic CP_DISABLE_REQ,
	input wire logic DRIVE_DISABLE_REQ,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic CP_UP,
	output logic CP_DN,
	output logic [1:0] CP_CUR,
	output logic CP_OE,
	output logic DRIVE_EN,
	output logic [3:0] PORT_O,
	output logic [3:0] PORT_OE,
	output logic LOCK_O,
	output logic LOCK_OE
);
	typedef struct packed {
		logic [WORD_W-1:0] sh;
	} lnk_t;

	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic en_d;
		logic rf_d;
		logic [WORD_W-1:0] word;
		logic [7:0] lock_thr;
		logic half_t;
		logic cp_up;
		logic cp_dn;
		logic [1:0] cp_cur;
		logic cp_oe;
		logic drive_en;
		logic [3:0] port_o;
		logic [3:0] port_oe;
		logic lock_o;
		logic lock_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sys_t;

	lnk_t lnk_q;
	lnk_t lnk_d;
	sys_t q;
	sys_t d;

	logic en_fall;
	logic rf_rise;
	logic test_on;
	logic cp_off;
	logic drv_off;
	logic skip;
	logic [2:0] tcode;
	logic [1:0] sel;
	logic pre_p;
	logic main_p;
	logic ref_p;
	logic [8:0] ratio;
	logic [31:0] stat;
	logic wr_go;

	pump_if pif ();

	// link side: serial shift register on the bus clock
	always_comb begin
		lnk_d = lnk_q;
		if (LINK_EN) begin
			lnk_d.sh = {lnk_q.sh[WORD_W-2:0], LINK_DATA};
		end
	end

	always_ff @(posedge LINK_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// pin conditioning
	assign en_fall = q.en_d & ~q.s2[PIN_EN];
	assign rf_rise = q.s2[PIN_RF] & ~q.rf_d;
	assign test_on = q.s2[PIN_TST];
	assign cp_off = q.s2[PIN_CPD];
	assign drv_off = q.s2[PIN_DRV];
	assign skip = q.s2[PIN_SKP];
	assign sel = {q.word[SEL_LO_BIT], q.word[SEL_HI_BIT]};
	assign tcode = {q.word[PORT_LSB+1], q.word[PORT_LSB+2],
		q.word[PORT_LSB+3]};
	assign ratio = ref_ratio(skip, sel);

	div_pulse #(.W(DIV_W)) u_pre (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.in_pulse(rf_rise),
		.ratio(PRESCALE),
		.out_pulse(pre_p)
	);

	div_pulse #(.W(DIV_W)) u_main (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.in_pulse(pre_p),
		.ratio(q.word[DIV_LSB+:DIV_W]),
		.out_pulse(main_p)
	);

	div_pulse #(.W(DIV_W)) u_ref (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.in_pulse(1'b1),
		.ratio({5'h00, ratio}),
		.out_pulse(ref_p)
	);

	pfd_lock u_pfd (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.ref_p(ref_p),
		.div_p(main_p),
		.thr(q.lock_thr),
		.pif(pif)
	);

	assign stat = {25'h0000000, skip, q.drive_en, q.cp_oe, q.cp_cur,
		test_on, pif.locked};
	assign wr_go = PSEL & PENABLE & q.pready & PWRITE;

	always_comb begin
		d = q;
		d.s1 = {REF_HALVING_SKIP, DRIVE_DISABLE_REQ, CP_DISABLE_REQ,
			TEST_REQ, RF_IN, LINK_EN};
		d.s2 = q.s1;
		d.en_d = q.s2[PIN_EN];
		d.rf_d = q.s2[PIN_RF];
		if (en_fall) begin
			d.word = lnk_q.sh;
		end
		if (main_p) begin
			d.half_t = ~q.half_t;
		end
		// normal operation
		d.cp_up = pif.up;
		d.cp_dn = pif.dn;
		d.cp_cur = pif.locked ? CUR_50 : CUR_150;
		d.lock_oe = pif.locked;
		d.port_oe = q.word[PORT_LSB+:PORT_W];
		d.port_o = 4'h0;
		d.lock_o = 1'b0;
		if (test_on) begin
			case (tcode)
				TC_DN170: begin
					d.cp_up = 1'b0;
					d.cp_dn = 1'b1;
					d.cp_cur = CUR_170;
				end
				TC_UP170: begin
					d.cp_up = 1'b1;
					d.cp_dn = 1'b0;
					d.cp_cur = CUR_170;
				end
				TC_DN50: begin
					d.cp_up = 1'b0;
					d.cp_dn = 1'b1;
					d.cp_cur = CUR_50;
				end
				TC_UP50: begin
					d.cp_up = 1'b1;
					d.cp_dn = 1'b0;
					d.cp_cur = CUR_50;
				end
				default: begin
				end
			endcase
			if (tcode[1:0] == TC_ROUTE) begin
				d.port_oe[2] = ref_p;
				d.port_oe[3] = q.half_t;
				d.lock_oe = 1'b0;
			end else if (tcode[1:0] == TC_FORCE) begin
				d.lock_oe = 1'b1;
			end
		end
		if (cp_off) begin
			d.cp_up = 1'b0;
			d.cp_dn = 1'b0;
		end
		d.cp_oe = ~cp_off;
		d.drive_en = ~drv_off;
		// register bus slave, one wait-free access phase
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (PSEL && !PENABLE) begin
			d.pready = 1'b1;
			case (PADDR)
				OFF_WORD: d.prdata = {12'h000, q.word};
				OFF_STAT: d.prdata = stat;
				OFF_LOCK: d.prdata = {24'h000000, q.lock_thr};
				default: begin
					d.prdata = 32'h00000000;
					d.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_go && PADDR == OFF_LOCK) begin
			d.lock_thr = PWDATA[7:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= '0;
			q.word <= WORD_RST;
			q.lock_thr <= LOCK_THR_RST;
			q.cp_cur <= CUR_150;
		end else begin
			q <= d;
		end
	end

	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = q.pslverr;
	assign CP_UP = q.cp_up;
	assign CP_DN = q.cp_dn;
	assign CP_CUR = q.cp_cur;
	assign CP_OE = q.cp_oe;
	assign DRIVE_EN = q.drive_en;
	assign PORT_O = q.port_o;
	assign PORT_OE = q.port_oe;
	assign LOCK_O = q.lock_o;
	assign LOCK_OE = q.lock_oe;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);

	sequence s_en_fall;
		q.s2[PIN_EN] ##1 !q.s2[PIN_EN];
	endsequence

	sequence s_normal;
		!test_on && !cp_off;
	endsequence

	a_shift_hold: assert property (@(posedge LINK_CLK)
		disable iff (!RESET_N)
		!LINK_EN |=> $stable(lnk_q.sh))
		else $error("shift register moved with enable low");

	a_shift_in: assert property (@(posedge LINK_CLK)
		disable iff (!RESET_N)
		LINK_EN |=> lnk_q.sh == {$past(lnk_q.sh[WORD_W-2:0]),
			$past(LINK_DATA)})
		else $error("serial bit not shifted in");

	a_latch_fall: assert property (
		s_en_fall |=> q.word == $past(lnk_q.sh))
		else $error("word not latched on enable fall");

	a_latch_hold: assert property (
		!en_fall |=> $stable(q.word))
		else $error("latched word changed without enable fall");

	a_port_sink: assert property (
		!test_on |=> PORT_OE == $past(q.word[PORT_LSB+:PORT_W]))
		else $error("port output not following its bit");

	a_cp_step: assert property (
		s_normal ##0 pif.locked |=> CP_CUR == CUR_50)
		else $error("pump current not reduced on lock");

	a_cp_start: assert property (
		s_normal ##0 !pif.locked |=> CP_CUR == CUR_150)
		else $error("pump current not at start value");

	a_test_pump: assert property (
		test_on && !cp_off && tcode == TC_DN170
		|=> CP_DN && !CP_UP && CP_CUR == CUR_170)
		else $error("test pump code not applied");

	a_lock_force: assert property (
		test_on && tcode[1:0] == TC_ROUTE |=> !LOCK_OE)
		else $error("lock output not forced out of lock");

	a_lock_flag: assert property (
		!test_on |=> LOCK_OE == $past(pif.locked) && !LOCK_O)
		else $error("lock output not tracking detector");

	a_cp_disable: assert property (
		cp_off |=> !CP_UP && !CP_DN && !CP_OE)
		else $error("pump active while disabled");

	a_drive_off: assert property (
		drv_off |=> !DRIVE_EN)
		else $error("varactor drive active while disabled");

	a_prescale_gap: assert property (
		pre_p |=> !pre_p [*8])
		else $error("prescaler pulses too close");

	a_ref_gap: assert property (
		ref_p |=> !ref_p [*8])
		else $error("reference pulses too close");

	a_apb_ready: assert property (
		PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("bus answer not one access cycle");
endmodule : synth_ctrl

// [verification/serial_host.sv]
// host model driving the three-wire load bus
module serial_host (
	output logic link_clk,
	output logic link_data,
	output logic link_en
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_clk = 1'b0;
		link_en = 1'b0;
		link_data = 1'b0;
	end
	// n bits msb first, clock idle low between frames
	task automatic send(input logic [23:0] w, input int n);
		#3 link_en = 1'b1;
		#300;
		for (int i = n - 1; i >= 0; i--) begin
			link_data = w[i];
			#37 link_clk = 1'b1;
			#43 link_clk = 1'b0;
		end
		#300;
	endtask : send
	// end of load, data no longer held
	task automatic drop();
		link_en = 1'b0;
		link_data = ~link_data;
	endtask : drop
	// clock pulses with enable low
	task automatic stray(input int n);
		link_data = 1'b1;
		for (int i = 0; i < n; i++) begin
			#37 link_clk = 1'b1;
			#43 link_clk = 1'b0;
		end
		link_data = 1'b0;
	endtask : stray
endmodule : serial_host

// [verification/three_wire_synth_control_tb.sv]
// self-checking bench for the synthesiser control block
module three_wire_synth_control_tb import synth_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, link_clk, link_data, link_en, rf_in, skip, rf_on;
	logic test_req, cpd_req, drv_req, psel, penable, pwrite, err;
	logic pready, pslverr, cp_up, cp_dn, cp_oe, drive_en, lock_oe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] cp_cur;
	logic [3:0] port_oe;
	logic [2:0] tc [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
	logic [1:0] tcur [4] = '{CUR_170, CUR_170, CUR_50, CUR_50};
	int rt [8] = '{280, 50, 500, 100, 140, 25, 250, 50};
	int fail_count, checked, p;
	synth_ctrl uut (.SYS_CLK(sys_clk), .RESET_N(rst_n),
		.LINK_CLK(link_clk), .LINK_DATA(link_data), .LINK_EN(link_en),
		.RF_IN(rf_in), .REF_HALVING_SKIP(skip), .TEST_REQ(test_req),
		.CP_DISABLE_REQ(cpd_req), .DRIVE_DISABLE_REQ(drv_req),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CP_UP(cp_up), .CP_DN(cp_dn),
		.CP_CUR(cp_cur), .CP_OE(cp_oe), .DRIVE_EN(drive_en),
		.PORT_O(), .PORT_OE(port_oe), .LOCK_O(), .LOCK_OE(lock_oe));
	serial_host host (.link_clk(link_clk), .link_data(link_data),
		.link_en(link_en));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// slow input for the prescaled path, one rise per four cycles
	initial begin
		rf_in = 1'b0;
		forever begin
			repeat (2) @(posedge sys_clk);
			if (rf_on === 1'b1)
				rf_in <= ~rf_in;
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			fail_count++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic load(input logic [19:0] w);
		host.send({4'h0, w}, 20);
		host.drop();
		cyc(10);
	endtask : load
	// cycles between third and fourth rise of a pulse output
	task automatic period(input int b, output int n);
		int k, t;
		logic pv;
		k = 0;
		pv = port_oe[b];
		for (n = 0; n < 3000 && k < 4; n++) begin
			@(negedge sys_clk);
			if (port_oe[b] === 1'b1 && pv !== 1'b1) begin
				k++;
				if (k == 3)
					t = n;
			end
			pv = port_oe[b];
		end
		if (k < 4) begin
			fail_count++;
			report_and_stop();
		end
		n = n - 1 - t;
	endtask : period
	initial begin
		{rst_n, rf_on, skip, test_req, cpd_req, drv_req} = '0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		cyc(6);
		check("cp_cur", cp_cur, CUR_150);
		check("lock_oe", lock_oe, 1'b0);
		check("port_oe", port_oe, 4'h0);
		apb(1'b0, OFF_LOCK, 32'h0);
		check("lock thr", rd, LOCK_THR_RST);
		apb(1'b0, 8'h0C, 32'h0);
		check("slverr", err, 1'b1);
		$display("reset test done");
		host.send(24'hFA5123, 24);
		cyc(10);
		check("port early", port_oe, 4'h0);
		host.drop();
		cyc(10);
		check("port", port_oe, 4'hA);
		apb(1'b0, OFF_WORD, 32'h0);
		check("word", rd, 32'h000A5123);
		host.stray(6);
		host.send(24'h000000, 0);
		host.drop();
		cyc(10);
		apb(1'b0, OFF_WORD, 32'h0);
		check("stray", rd, 32'h000A5123);
		$display("load test done");
		cpd_req <= 1'b1;
		drv_req <= 1'b1;
		cyc(8);
		check("cp_oe off", cp_oe, 1'b0);
		check("drive off", drive_en, 1'b0);
		apb(1'b0, OFF_STAT, 32'h0);
		check("stat", rd, 32'h00000004);
		cpd_req <= 1'b0;
		drv_req <= 1'b0;
		cyc(8);
		check("cp_oe on", cp_oe, 1'b1);
		check("drive on", drive_en, 1'b1);
		$display("disable test done");
		test_req <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			load({tc[i][0], tc[i][1], tc[i][2], 17'h0});
			check("cp_up", cp_up, tc[i][0]);
			check("cp_dn", cp_dn, !tc[i][0]);
			check("cp_cur", cp_cur, tcur[i]);
		end
		load(20'hC0000);
		check("lock forced", lock_oe, 1'b1);
		for (int m = 0; m < 8; m++) begin
			skip <= m[2];
			load({4'h4, m[0], m[1], 14'h0});
			check("lock out", lock_oe, 1'b0);
			period(2, p);
			check("ratio", p, rt[m]);
		end
		rf_on <= 1'b1;
		load(20'h40003);
		period(3, p);
		check("main div", p, 2 * 16 * 3 * 4);
		$display("test mode done");
		test_req <= 1'b0;
		apb(1'b1, OFF_LOCK, 32'h0);
		cyc(2000);
		check("locked", lock_oe, 1'b1);
		check("cp_cur lock", cp_cur, CUR_50);
		$display("lock test done");
		report_and_stop();
	end
endmodule : three_wire_synth_control_tb
